// ==== cttpf_pkg.sv ====
// shared constants and carrier types of the core trace packet formatter
package cttpf_pkg;
  // register byte offsets
  localparam logic [7:0] SW_CTRL_OFFS    = 8'h00;
  localparam logic [7:0] PROBE_CTRL_OFFS = 8'h04;
  localparam logic [7:0] STATUS_OFFS     = 8'h08;
  localparam logic [7:0] PKT_COUNT_OFFS  = 8'h0C;
  // control field positions (shared by both control registers)
  localparam int TRACE_EN_BIT   = 0;
  localparam int CYC_ACC_BIT    = 1;
  localparam int OPT_BITS_BIT   = 2;
  localparam int PERF_EN_BIT    = 3;
  localparam int PROBE_OWNS_BIT = 4;
  localparam int ADDR_WIDTH_BIT = 23;
  localparam int EXPAND_BIT     = 28;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // completion type codes
  localparam logic [3:0] NO_GRADUATION_CODE = 4'h0;
  localparam logic [3:0] COMP_PLAIN         = 4'h1;
  localparam logic [3:0] COMP_LOAD          = 4'h2;
  localparam logic [3:0] COMP_STORE         = 4'h3;
  localparam logic [3:0] COMP_PC_SYNC       = 4'h4;
  localparam logic [3:0] COMP_BRANCH        = 4'h5;
  localparam logic [3:0] COMP_BR_LOAD       = 4'h6;
  localparam logic [3:0] COMP_BR_STORE      = 4'h7;
  localparam logic [3:0] COMP_FIRST_RSVD    = 4'hC;
  // transfer type codes
  localparam logic [2:0] XFER_NONE_CODE     = 3'h0;
  localparam logic [2:0] DATA_TRANSFER_CODE = 3'h1;
  // fourth format fixed pattern: end flag one over data-transfer code
  localparam logic [3:0] FMT_FOUR_MARK = {1'b1, DATA_TRANSFER_CODE};
  // field bases and widths
  localparam logic [5:0] FMT_THREE_AD_BASE   = 6'd12;
  localparam logic [5:0] FMT_FOUR_AD_BASE    = 6'd16;
  localparam logic [5:0] FMT_FOUR_X_AD_BASE  = 6'd17;
  localparam logic [5:0] AD_NARROW           = 6'd16;
  localparam logic [5:0] AD_WIDE             = 6'd32;
  localparam logic [5:0] FMT_THREE_OPT_COUNT = 6'd2;
  localparam logic [5:0] FMT_FOUR_OPT_COUNT  = 6'd3;
  localparam int         PKT_W               = 52;
  localparam int         FIFO_DEPTH          = 16;
  // one graduation slot from the pipeline
  typedef struct packed {
    logic        valid;        // an instruction graduated
    logic [3:0]  comp;         // completion type
    logic        fetch_miss;   // fetch miss bit
    logic        call_ret;     // call/return tag
    logic        data_miss;    // data cache miss
    logic        xfer_valid;   // address/data transfer present
    logic [2:0]  xfer_type;    // transfer type
    logic        xfer_end;     // last cycle of the transfer
    logic [4:0]  order_tag;    // transaction order tag
    logic        is_addr;      // ad carries an address
    logic        perf_valid;   // ad carries a counter value
    logic [31:0] ad;           // address, data or counter
  } cttpf_grad_t;
  // one formatted packet with its width
  typedef struct packed {
    logic [5:0]       len;     // valid bits from bit 0
    logic [PKT_W-1:0] data;    // packet, unused top bits zero
  } cttpf_pkt_t;
  localparam int PKT_T_W = PKT_W + 6;
endpackage

// ==== cttpf_formatter.sv ====
// trace packet fifo and the formatter top with its register slave
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module cttpf_fifo #(
  parameter int WIDTH = 58,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,       // core clock
  input  wire logic             rst_n,     // async reset
  input  wire logic             s_valid,   // push request
  output logic                  s_ready,   // room available
  input  wire logic [WIDTH-1:0] s_data,    // push word
  output logic                  m_valid,   // word available
  input  wire logic             m_ready,   // pop request
  output logic [WIDTH-1:0]      m_data,    // head word
  output logic [$clog2(DEPTH):0] count     // words held
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("fifo depth must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             push;
  logic             pop;
  // full and empty from the extra pointer bit
  assign count   = wr_ptr_r - rd_ptr_r;
  assign s_ready = (count != DEPTH[AW:0]);
  assign m_valid = (count != '0);
  assign m_data  = mem[rd_ptr_r[AW-1:0]];
  assign push    = s_valid && s_ready;
  assign pop     = m_valid && m_ready;
  // storage, no reset needed on data
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_r[AW-1:0]] <= s_data;
  end
  // pointers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module cttpf_formatter #(
  parameter int FIFO_DEPTH = cttpf_pkg::FIFO_DEPTH
) (
  input  wire logic                      SYS_CLK,       // core clock, 250 MHz
  input  wire logic                      NRST,          // async reset, low
  input  wire logic                      GRAD_VALID,    // slot pair offered
  output logic                           GRAD_READY,    // slot pair taken
  input  wire cttpf_pkg::cttpf_grad_t    GRAD_SLOT0,    // graduation slot 0
  input  wire cttpf_pkg::cttpf_grad_t    GRAD_SLOT1,    // graduation slot 1
  output logic                           TRACE_VALID,   // packet valid
  input  wire logic                      TRACE_READY,   // sink takes packet
  output cttpf_pkg::cttpf_pkt_t          TRACE_PKT,     // packet and width
  input  wire logic [7:0]                S_AXI_AWADDR,  // write address
  input  wire logic                      S_AXI_AWVALID, // write address valid
  output logic                           S_AXI_AWREADY, // write address ready
  input  wire logic [31:0]               S_AXI_WDATA,   // write data
  input  wire logic [3:0]                S_AXI_WSTRB,   // byte enables
  input  wire logic                      S_AXI_WVALID,  // write data valid
  output logic                           S_AXI_WREADY,  // write data ready
  output logic [1:0]                     S_AXI_BRESP,   // write response
  output logic                           S_AXI_BVALID,  // write response valid
  input  wire logic                      S_AXI_BREADY,  // write response ready
  input  wire logic [7:0]                S_AXI_ARADDR,  // read address
  input  wire logic                      S_AXI_ARVALID, // read address valid
  output logic                           S_AXI_ARREADY, // read address ready
  output logic [31:0]                    S_AXI_RDATA,   // read data
  output logic [1:0]                     S_AXI_RRESP,   // read response
  output logic                           S_AXI_RVALID,  // read data valid
  input  wire logic                      S_AXI_RREADY   // read data ready
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  initial
  begin
    if (FIFO_DEPTH < 4 || FIFO_DEPTH > 32)
      $error("formatter fifo needs 4 to 32 entries");
  end
  typedef enum logic [1:0] {
    CTTPF_IDLE  = 2'b00,
    CTTPF_SLOT0 = 2'b01,
    CTTPF_SLOT1 = 2'b11
  } cttpf_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // packet assembly for one slot
  function automatic cttpf_pkg::cttpf_pkt_t build_pkt(
    input cttpf_pkg::cttpf_grad_t s,
    input logic                   expand,
    input logic                   addr_wide,
    input logic                   opt_en,
    input logic                   perf_en
  );
    cttpf_pkg::cttpf_pkt_t p;
    logic [51:0] d;
    logic [51:0] adv;
    logic [51:0] optv;
    logic        wide;
    logic        end_fmt;
    logic        ctr_pkt;
    logic [5:0]  aw;
    logic [5:0]  base;
    logic [5:0]  len;
    d    = '0;
    optv = '0;
    ctr_pkt = perf_en && s.perf_valid;
    // narrow when the address width bit is clear or ad is a non-counter address that fits in 16 bits
    // wide variant and mode one otherwise
    wide = addr_wide && (!s.is_addr || ctr_pkt || (s.ad[31:16] != 16'h0000));
    aw   = wide ? cttpf_pkg::AD_WIDE : cttpf_pkg::AD_NARROW;
    adv  = wide ? {20'h00000, s.ad} : {36'h000000000, s.ad[15:0]};
    // fourth format only on the closing data cycle
    // same format for load and store data
    end_fmt = s.xfer_valid && !ctr_pkt && s.xfer_type == cttpf_pkg::DATA_TRANSFER_CODE
              && s.xfer_end;
    if (end_fmt)
    begin
      if (expand)
      begin
        // expansion widens completion to four bits
        d[6:3]   = s.comp;
        d[10:7]  = cttpf_pkg::FMT_FOUR_MARK;
        d[11]    = wide;
        d[16:12] = s.order_tag;
        base     = cttpf_pkg::FMT_FOUR_X_AD_BASE;
      end
      else
      begin
        d[5:3]   = s.comp[2:0];
        d[9:6]   = cttpf_pkg::FMT_FOUR_MARK;
        d[10]    = wide;
        d[15:11] = s.order_tag;
        base     = cttpf_pkg::FMT_FOUR_AD_BASE;
      end
      optv = {49'h0, s.data_miss, s.fetch_miss, s.call_ret} << (base + aw);
      len  = base + aw + (opt_en ? cttpf_pkg::FMT_FOUR_OPT_COUNT : 6'd0);
    end
    else
    begin
      // third layout, type 9:7, end 10, mode 11
      base   = cttpf_pkg::FMT_THREE_AD_BASE;
      d[6:3] = s.comp;
      d[11]  = wide;
      // counter packets are data-transfer, end zero
      if (ctr_pkt)
        d[9:7] = cttpf_pkg::DATA_TRANSFER_CODE;
      else if (s.xfer_valid)
      begin
        d[9:7] = s.xfer_type;
        d[10]  = s.xfer_end;
      end
      else
        d[9:7] = cttpf_pkg::XFER_NONE_CODE;
      optv = {50'h0, s.fetch_miss, s.call_ret} << (base + aw);
      // 28 or 44 bits before optional bits
      len  = base + aw + (opt_en ? cttpf_pkg::FMT_THREE_OPT_COUNT : 6'd0);
      // flag above the optional bits, AD holds counter
      if (perf_en)
      begin
        d   = d | ({51'h0, ctr_pkt} << len);
        len = len + 6'd1;
      end
    end
    d = d | (adv << base);
    if (opt_en)
      d = d | optv;
    p.len  = len;
    p.data = d;
    return p;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // control and status registers
  logic [31:0]  sw_ctrl_r;
  logic [31:0]  probe_ctrl_r;
  logic [31:0]  pkt_count_r;
  logic         sink_stall_r;
  logic [31:0]  ctrl;
  logic [CW-1:0] fifo_count;
  // probe copy steers the block when it owns the trace
  assign ctrl = sw_ctrl_r[cttpf_pkg::PROBE_OWNS_BIT] ? probe_ctrl_r : sw_ctrl_r;

  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_fire;
  assign wr_fire = aw_hold_r && w_hold_r && !S_AXI_BVALID;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // write address and data taken in either order, response after both
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'b00;
    end
    else
    begin
      S_AXI_AWREADY <= !aw_hold_r && !S_AXI_AWREADY;
      S_AXI_WREADY  <= !w_hold_r && !S_AXI_WREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_hold_r     <= 1'b1;
        aw_addr_r     <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_hold_r     <= 1'b1;
        w_data_r     <= S_AXI_WDATA;
        w_strb_r     <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        if (aw_addr_r == cttpf_pkg::SW_CTRL_OFFS || aw_addr_r == cttpf_pkg::PROBE_CTRL_OFFS)
          S_AXI_BRESP <= 2'b00;
        else
          S_AXI_BRESP <= 2'b10;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  // control register contents
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sw_ctrl_r    <= cttpf_pkg::CTRL_RESET;
      probe_ctrl_r <= cttpf_pkg::CTRL_RESET;
    end
    else if (wr_fire)
    begin
      if (aw_addr_r == cttpf_pkg::SW_CTRL_OFFS)
        sw_ctrl_r <= merge(sw_ctrl_r, w_data_r, w_strb_r);
      else if (aw_addr_r == cttpf_pkg::PROBE_CTRL_OFFS)
        probe_ctrl_r <= merge(probe_ctrl_r, w_data_r, w_strb_r);
    end
  end

  // read channel, one cycle after the address is taken
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= 2'b00;
    end
    else
    begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RRESP   <= 2'b00;
        if (S_AXI_ARADDR == cttpf_pkg::SW_CTRL_OFFS)
          S_AXI_RDATA <= sw_ctrl_r;
        else if (S_AXI_ARADDR == cttpf_pkg::PROBE_CTRL_OFFS)
          S_AXI_RDATA <= probe_ctrl_r;
        else if (S_AXI_ARADDR == cttpf_pkg::STATUS_OFFS)
          S_AXI_RDATA <= {23'h000000, sink_stall_r, GRAD_READY, {(7 - CW){1'b0}}, fifo_count};
        else if (S_AXI_ARADDR == cttpf_pkg::PKT_COUNT_OFFS)
          S_AXI_RDATA <= pkt_count_r;
        else
        begin
          S_AXI_RDATA <= 32'h0000_0000;
          S_AXI_RRESP <= 2'b10;
        end
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // slot sequencing
  cttpf_state_t          state_r;
  cttpf_state_t          state_nxt;
  cttpf_pkg::cttpf_pkt_t pend_r [2];
  logic [1:0]            pend_v_r;
  logic                  take;
  logic                  push_v;
  logic                  push_rdy;
  cttpf_pkg::cttpf_pkt_t push_pkt;
  cttpf_pkg::cttpf_grad_t slot_in [2];
  logic [1:0]            slot_emit;

  assign take = GRAD_VALID && GRAD_READY;

  // empty slots become no-graduation packets in cycle-accurate mode
  always_comb
  begin
    slot_in[0] = GRAD_SLOT0;
    slot_in[1] = GRAD_SLOT1;
    for (int i = 0; i < 2; i++)
    begin
      slot_emit[i] = ctrl[cttpf_pkg::TRACE_EN_BIT]
                     && (slot_in[i].valid || ctrl[cttpf_pkg::CYC_ACC_BIT]);
      if (!slot_in[i].valid)
      begin
        slot_in[i].comp       = cttpf_pkg::NO_GRADUATION_CODE;
        slot_in[i].xfer_valid = 1'b0;
        slot_in[i].perf_valid = 1'b0;
      end
    end
  end

  // slot 0 always pushed ahead of slot 1
  always_comb
  begin
    state_nxt = state_r;
    push_v    = 1'b0;
    push_pkt  = pend_r[0];
    case (state_r)
      CTTPF_IDLE:
        if (take)
          state_nxt = CTTPF_SLOT0;
      CTTPF_SLOT0:
      begin
        push_v = pend_v_r[0];
        if (!pend_v_r[0] || push_rdy)
          state_nxt = CTTPF_SLOT1;
      end
      CTTPF_SLOT1:
      begin
        push_v   = pend_v_r[1];
        push_pkt = pend_r[1];
        if (!pend_v_r[1] || push_rdy)
          state_nxt = CTTPF_IDLE;
      end
      default:
        state_nxt = CTTPF_IDLE;
    endcase
  end

  // state and pending packets, ready only while idle
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_r    <= CTTPF_IDLE;
      pend_v_r   <= 2'b00;
      pend_r[0]  <= '0;
      pend_r[1]  <= '0;
      GRAD_READY <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      GRAD_READY <= (state_nxt == CTTPF_IDLE) && !take;
      if (take)
      begin
        pend_v_r <= slot_emit;
        for (int i = 0; i < 2; i++)
          pend_r[i] <= build_pkt(slot_in[i], ctrl[cttpf_pkg::EXPAND_BIT],
                                 ctrl[cttpf_pkg::ADDR_WIDTH_BIT],
                                 ctrl[cttpf_pkg::OPT_BITS_BIT],
                                 ctrl[cttpf_pkg::PERF_EN_BIT]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // packet fifo and registered output stage
  logic                  fifo_v;
  logic                  fifo_pop;
  cttpf_pkg::cttpf_pkt_t fifo_pkt;
  assign fifo_pop = !TRACE_VALID || TRACE_READY;

  cttpf_fifo #(
    .WIDTH (cttpf_pkg::PKT_T_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk     (SYS_CLK),
    .rst_n   (NRST),
    .s_valid (push_v),
    .s_ready (push_rdy),
    .s_data  (push_pkt),
    .m_valid (fifo_v),
    .m_ready (fifo_pop),
    .m_data  (fifo_pkt),
    .count   (fifo_count)
  );

  // output register; sink stall backs up into the fifo and the pipeline
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      TRACE_VALID <= 1'b0;
      TRACE_PKT   <= '0;
    end
    else if (fifo_pop)
    begin
      TRACE_VALID <= fifo_v;
      if (fifo_v)
        TRACE_PKT <= fifo_pkt;
    end
  end

  // delivered packet count and sticky sink stall, write to status clears nothing
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pkt_count_r  <= 32'h0000_0000;
      sink_stall_r <= 1'b0;
    end
    else
    begin
      if (TRACE_VALID && TRACE_READY)
        pkt_count_r <= pkt_count_r + 32'h0000_0001;
      if (push_v && !push_rdy)
        sink_stall_r <= 1'b1;
      else if (wr_fire && aw_addr_r == cttpf_pkg::SW_CTRL_OFFS)
        sink_stall_r <= 1'b0;
    end
  end
endmodule

// ==== cttpf_formatter_monitor.sv ====
// port checker for the trace packet formatter
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module cttpf_formatter_monitor #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic                  SYS_CLK,     // core clock
  input wire logic                  NRST,        // reset, low
  input wire logic                  GRAD_VALID,  // pair offered
  input wire logic                  GRAD_READY,  // pair taken
  input wire logic                  TRACE_VALID, // packet valid
  input wire logic                  TRACE_READY, // sink ready
  input wire cttpf_pkg::cttpf_pkt_t TRACE_PKT    // packet, width
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);
  logic [5:0]  ln;    // packet width
  logic [51:0] dt;    // packet bits
  logic        stuck; // sink holding off
  // field views; the width tells format apart since the lengths never overlap
  assign ln = TRACE_PKT.len;
  assign dt = TRACE_PKT.data;
  assign stuck = TRACE_VALID && !TRACE_READY;
  pad_zero_a: assert property (TRACE_VALID |-> (dt >> ln) == 52'h0)
    else $error("bits above packet width set");
  low_zero_a: assert property (TRACE_VALID |-> dt[2:0] == 3'h0)
    else $error("packet low bits not zero");
  width_legal_a: assert property (TRACE_VALID |-> ln inside {[28:36], [44:52]})
    else $error("illegal packet width");
  narrow_mode_a: assert property (TRACE_VALID && ln inside {[28:31]} |-> !dt[11])
    else $error("narrow packet with mode one");
  wide_mode_a: assert property (TRACE_VALID && ln inside {[44:47]} |-> dt[11])
    else $error("wide packet with mode zero");
  end_mark_a: assert property (TRACE_VALID && ln inside {32,35,48,51} |-> dt[9:6] == 4'h9)
    else $error("fourth format marker wrong");
  wide_mark_a: assert property (TRACE_VALID && ln inside {33,36,49,52} |-> dt[10:7] == 4'h9)
    else $error("expanded fourth marker wrong");
  pkt_hold_a: assert property (stuck |=> TRACE_VALID && $stable(TRACE_PKT))
    else $error("packet changed while refused");
  slot_gap_a: assert property (GRAD_VALID && GRAD_READY |=> (!GRAD_READY) [*2])
    else $error("pair taken before both slots pushed");
  // main scenarios reached
  stall_c: cover property (stuck [*4]);
  full_c: cover property (TRACE_VALID && ln == 6'd52);
  empty_c: cover property (TRACE_VALID && ln == 6'd28 && dt == 52'h0);
endmodule

bind cttpf_formatter cttpf_formatter_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (
  .SYS_CLK, .NRST, .GRAD_VALID, .GRAD_READY, .TRACE_VALID, .TRACE_READY, .TRACE_PKT
);

// ==== cttpf_sink_model.sv ====
// trace sink model: takes packets promptly, slowly or not at all
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module cttpf_sink_model (
  input  wire logic clk,   // core clock
  input  wire logic rst_n, // reset, low
  input  wire logic stall, // refuse everything
  input  wire logic slow,  // take every other cycle
  output logic      ready  // packet taken
);
  logic tog_r; // phase of the slow pattern
  // ready moves just after the edge, as a real buffer would
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tog_r <= 1'b0;
      ready <= 1'b0;
    end
    else
    begin
      tog_r <= ~tog_r;
      ready <= !stall && (!slow || tog_r);
    end
  end
endmodule

// ==== tb_cttpf_formatter.sv ====
// self-checking bench for the trace packet formatter
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module tb_cttpf_formatter;
  localparam logic [4:0]  xa = 5'h14;                     // address, not last
  localparam logic [4:0]  xd = 5'h13;                     // data, last cycle
  logic                   sys_clk, nrst, stall, slow;     // clock, reset, sink modes
  logic                   grad_valid, grad_ready, trace_valid, trace_ready; // handshakes
  cttpf_pkg::cttpf_grad_t slot0, slot1;                   // slots
  cttpf_pkg::cttpf_pkt_t  pkt;                            // packet out
  cttpf_pkg::cttpf_pkt_t  q[$];                           // packets taken
  logic [7:0]             awaddr, araddr;                 // addresses
  logic [31:0]            wdata, rdata;                   // data
  logic [1:0]             bresp, rresp;                   // responses
  logic                   awvalid, awready, wvalid, wready; // write strobes
  logic                   bvalid, bready, arvalid, arready, rvalid, rready; // rest
  int                     error_cnt = 0, compares = 0;    // tallies
  // device under test; all byte lanes enabled
  cttpf_formatter #(.FIFO_DEPTH(16)) dut (
    .SYS_CLK(sys_clk), .NRST(nrst), .GRAD_VALID(grad_valid), .GRAD_READY(grad_ready),
    .GRAD_SLOT0(slot0), .GRAD_SLOT1(slot1), .TRACE_VALID(trace_valid),
    .TRACE_READY(trace_ready), .TRACE_PKT(pkt), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  cttpf_sink_model sink (.clk(sys_clk), .rst_n(nrst), .stall(stall), .slow(slow),
                         .ready(trace_ready));
  // 250 MHz core clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // every packet the sink takes is queued for the scenarios
  always @(posedge sys_clk)
    if (trace_valid && trace_ready)
      q.push_back(pkt);
  task automatic chk(string n, logic [57:0] s, logic [57:0] e);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // bus tasks end one edge late so no strobe is driven twice in a step
  task automatic wrc(logic [7:0] a, logic [31:0] d, logic [1:0] e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    chk("bresp", 58'(bresp), 58'(e));
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdc(string n, logic [7:0] a, logic [31:0] e, logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    chk(n, {rresp, rdata}, {er, e});
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic ctl(logic [31:0] d);
    wrc(cttpf_pkg::SW_CTRL_OFFS, d, 2'b00);
  endtask
  task automatic send(cttpf_pkg::cttpf_grad_t a, cttpf_pkg::cttpf_grad_t b);
    slot0 <= a;
    slot1 <= b;
    grad_valid <= 1'b1;
    do
      @(posedge sys_clk);
    while (!grad_ready);
    grad_valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rx(string n, logic [57:0] e);
    while (q.size() == 0)
      @(posedge sys_clk);
    chk(n, q.pop_front(), e);
  endtask
  // valid slot from comp, {fetch,callret,datamiss}, {xv,type,end}, tag, {addr,perf}, ad
  function automatic cttpf_pkg::cttpf_grad_t g(logic [3:0] c, logic [2:0] m, logic [4:0] x,
                                               logic [4:0] t, logic [1:0] k, logic [31:0] d);
    return {1'b1, c, m, x, t, k, d};
  endfunction
  task automatic t_regs();
    rdc("sw ctrl", cttpf_pkg::SW_CTRL_OFFS, 32'h0, 2'b00);
    rdc("probe ctrl", cttpf_pkg::PROBE_CTRL_OFFS, 32'h0, 2'b00);
    rdc("status", cttpf_pkg::STATUS_OFFS, 32'h80, 2'b00);
    rdc("count", cttpf_pkg::PKT_COUNT_OFFS, 32'h0, 2'b00);
    rdc("unmapped", 8'h10, 32'h0, 2'b10);
    wrc(8'h10, 32'hFFFF_FFFF, 2'b10);
    send(g(4'h1, 3'h0, xa, 5'h0, 2'b10, 32'h1), '0);
    repeat (8) @(posedge sys_clk);
    chk("idle", 58'(q.size()), 58'h0);
  endtask
  task automatic t_cyc();
    ctl(32'h3);
    send(g(4'h2, 3'h0, xa, 5'h0, 2'b10, 32'h1234), '0);
    rx("slot0", {6'd28, 52'({16'h1234, 2'b00, 3'h2, 4'h2, 3'h0})});
    rx("empty", {6'd28, 52'h0});
    ctl(32'h1);
    send('0, g(4'h1, 3'h0, xa, 5'h0, 2'b10, 32'h55));
    rx("dropped", {6'd28, 52'({16'h55, 2'b00, 3'h2, 4'h1, 3'h0})});
  endtask
  task automatic t_addr();
    ctl(32'h0080_0005);
    send(g(4'h5, 3'h5, xa, 5'h0, 2'b10, 32'hABCD_0010), g(4'h3, 3'h2, xa, 5'h0, 2'b10, 32'hF0));
    rx("wide", {6'd46, 52'({2'b10, 32'hABCD_0010, 2'b10, 3'h2, 4'h5, 3'h0})});
    rx("narrow", {6'd30, 52'({2'b01, 16'hF0, 2'b00, 3'h2, 4'h3, 3'h0})});
  endtask
  task automatic t_end();
    ctl(32'h1);
    send(g(4'h2, 3'h7, xd, 5'h15, 2'b00, 32'hBEEF), g(4'h3, 3'h0, xd, 5'h1, 2'b00, 32'h42));
    rx("load end", {6'd32, 52'({16'hBEEF, 5'h15, 1'b0, 4'h9, 3'h2, 3'h0})});
    rx("store end", {6'd32, 52'({16'h42, 5'h01, 1'b0, 4'h9, 3'h3, 3'h0})});
    ctl(32'h10);
    wrc(cttpf_pkg::PROBE_CTRL_OFFS, 32'h1080_0005, 2'b00);
    send(g(4'h7, 3'h7, xd, 5'h1F, 2'b00, 32'hCAFE_F00D), g(4'h2, 3'h1, xd, 5'h0, 2'b00, 32'h1));
    rx("expanded", {6'd52, 52'({3'h7, 32'hCAFE_F00D, 5'h1F, 1'b1, 4'h9, 4'h7, 3'h0})});
    rx("data miss", {6'd52, 52'({3'h4, 32'h1, 5'h0, 1'b1, 4'h9, 4'h2, 3'h0})});
  endtask
  task automatic t_perf();
    ctl(32'h9);
    send(g(4'h1, 3'h0, xd, 5'h0, 2'b01, 32'h777), '0);
    rx("counter", {6'd29, 52'({1'b1, 16'h777, 2'b00, 3'h1, 4'h1, 3'h0})});
    ctl(32'h0080_0009);
    send(g(4'h1, 3'h0, xd, 5'h0, 2'b01, 32'h5), '0);
    rx("counter wide", {6'd45, 52'({1'b1, 32'h5, 2'b10, 3'h1, 4'h1, 3'h0})});
  endtask
  // fill the buffer past full, then drain it through a slow sink
  task automatic t_full();
    ctl(32'h1);
    stall <= 1'b1;
    for (int i = 0; i < 9; i++)
      send(g(4'h1, 3'h0, xa, 5'h0, 2'b10, 32'(2*i)), g(4'h1, 3'h0, xa, 5'h0, 2'b10, 32'(2*i+1)));
    repeat (4) @(posedge sys_clk);
    rdc("full", cttpf_pkg::STATUS_OFFS, 32'h110, 2'b00);
    stall <= 1'b0;
    slow <= 1'b1;
    for (int i = 0; i < 18; i++)
      rx("drain", {6'd28, 52'({16'(i), 2'b00, 3'h2, 4'h1, 3'h0})});
    ctl(32'h1);
    rdc("cleared", cttpf_pkg::STATUS_OFFS, 32'h80, 2'b00);
    rdc("delivered", cttpf_pkg::PKT_COUNT_OFFS, 32'h1D, 2'b00);
  endtask
  // main sequence
  initial
  begin
    nrst = 1'b0;
    {grad_valid, stall, slow, slot0, slot1} = '0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_cyc();
    t_addr();
    t_end();
    t_perf();
    t_full();
    finish_test();
  end
  // watchdog: the whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    finish_test();
  end
endmodule
